// *** etc_timer_cascade.sv ***
`default_nettype none
module etc_timer_cascade
(
  // System
  input  wire logic                      clock,
  input  wire logic                      reset,
  input  wire logic                      clock_enable,
  // Timer controls
  input  wire logic [etc_pkg::CTL_W-1:0] first_timer_control,
  input  wire logic [etc_pkg::CTL_W-1:0] second_timer_control,
  // Clock sources
  input  wire logic [3:0]                source_ticks,
  // Channel control, bit 0 reserved
  input  wire logic [etc_pkg::CTL_W-1:0] channel_control,
  // Counts
  output logic [15:0]                    first_timer_count,
  output logic [15:0]                    second_timer_count,
  output logic [31:0]                    cascade_count,
  output logic                           first_timer_overflow_pulse,
  output logic                           second_timer_overflow_pulse,
  output logic                           channel_chain_signal
);
  import etc_pkg::*;

  // Control bit positions must fit inside the control word
  if (CASCADE_BIT >= CTL_W || DIR_BIT >= CTL_W || SRC_LSB + 1 >= CTL_W || PRE_LSB + 2 >= CTL_W)
  begin : g_bad_layout
    $error("Control bit position outside control word");
  end

  typedef struct packed
  {
    logic [15:0] t1;
    logic [15:0] t2;
    logic        ov1;
    logic        ov2;
  } etc_state_type;
  etc_state_type state_q;
  etc_state_type state_d;
  logic t2_src_tick;
  logic t2_pre_tick;
  logic t2_tick;
  logic t1_up;
  logic t2_up;
  logic cascade;

  function automatic logic wrap(input logic [15:0] v, input logic up);
    return up ? (v == 16'hFFFF) : (v == 16'h0000);
  endfunction : wrap
  function automatic logic [15:0] step(input logic [15:0] v, input logic up);
    return up ? 16'(v + 16'h0001) : 16'(v - 16'h0001);
  endfunction : step

  // Source for the prescaler is chosen before division
  assign t2_src_tick = source_ticks[second_timer_control[SRC_LSB+1:SRC_LSB]];
  etc_prescaler #(.DIV_W(3)) u_pre
  (
    .clock      (clock),
    .reset      (reset),
    .enable     (clock_enable),
    .div_select (second_timer_control[PRE_LSB+2:PRE_LSB]),
    .tick_in    (t2_src_tick),
    .tick_out   (t2_pre_tick)
  );

  assign cascade = second_timer_control[CASCADE_BIT];
  // Overflow bypasses the prescaler, hence the mux after it
  assign t2_tick = cascade ? state_q.ov1 : t2_pre_tick;
  assign t1_up = first_timer_control[DIR_BIT];
  assign t2_up = cascade ? t1_up : second_timer_control[DIR_BIT];

  always_comb
  begin
    state_d = state_q;
    state_d.ov1 = 1'b0;
    state_d.ov2 = 1'b0;
    if (source_ticks[0])
    begin
      state_d.t1 = step(state_q.t1, t1_up);
      state_d.ov1 = wrap(state_q.t1, t1_up);
    end
    if (t2_tick)
    begin
      state_d.t2 = step(state_q.t2, t2_up);
      state_d.ov2 = wrap(state_q.t2, t2_up);
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_q <= '0;
      first_timer_count <= TIMER_RST;
      second_timer_count <= TIMER_RST;
      cascade_count <= 32'h0000_0000;
      first_timer_overflow_pulse <= 1'b0;
      second_timer_overflow_pulse <= 1'b0;
      channel_chain_signal <= 1'b0;
    end
    else if (clock_enable)
    begin
      state_q <= state_d;
      first_timer_count <= state_d.t1;
      second_timer_count <= state_d.t2;
      cascade_count <= {state_d.t2, state_d.t1};
      first_timer_overflow_pulse <= state_d.ov1;
      second_timer_overflow_pulse <= state_d.ov2;
      // Chaining never works, whatever software writes to the reserved bit
      channel_chain_signal <= 1'b0;
    end
  end

  // Step checks look one clock edge after their enabled cause

  AST_CASCADE_STEP: assert property (@(posedge clock) disable iff (reset)
    clock_enable && cascade && state_q.ov1
    |=> second_timer_count == step($past(second_timer_count),
                                   $past(first_timer_control[DIR_BIT])))
    else $error("Cascaded timer 2 did not step on overflow");

  AST_NO_STEP: assert property (@(posedge clock) disable iff (reset)
    clock_enable && cascade && !state_q.ov1
    |=> $stable(second_timer_count))
    else $error("Cascaded timer 2 moved without overflow");

  AST_CASCADE_DIR: assert property (@(posedge clock) disable iff (reset)
    clock_enable && cascade && state_q.ov1
    && (second_timer_control[DIR_BIT] != first_timer_control[DIR_BIT])
    |=> second_timer_count == step($past(second_timer_count),
                                   !$past(second_timer_control[DIR_BIT])))
    else $error("Cascaded timer 2 followed its own direction bit");

  AST_T1_DIR: assert property (@(posedge clock) disable iff (reset)
    clock_enable && source_ticks[0]
    |=> first_timer_count == step($past(first_timer_count),
                                  $past(first_timer_control[DIR_BIT])))
    else $error("Timer 1 did not step in its own direction");

  AST_T1_HOLD: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !source_ticks[0]
    |=> $stable(first_timer_count))
    else $error("Timer 1 moved without a tick");

  // Prescaled path, cascade off

  AST_PRESCALED_STEP: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !cascade && t2_pre_tick
    |=> second_timer_count == step($past(second_timer_count),
                                   $past(second_timer_control[DIR_BIT])))
    else $error("Timer 2 did not step on prescaler output");

  AST_PRESCALED_HOLD: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !cascade && !t2_pre_tick
    |=> $stable(second_timer_count))
    else $error("Timer 2 moved without prescaler output");

  // Overflow pulses

  AST_OV1_PULSE: assert property (@(posedge clock) disable iff (reset)
    clock_enable && source_ticks[0] && wrap(first_timer_count, first_timer_control[DIR_BIT])
    |=> first_timer_overflow_pulse)
    else $error("Timer 1 wrapped without overflow pulse");

  AST_OV1_QUIET: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !(source_ticks[0] && wrap(first_timer_count, first_timer_control[DIR_BIT]))
    |=> !first_timer_overflow_pulse)
    else $error("Timer 1 overflow pulse without wrap");

  AST_OV2_PULSE: assert property (@(posedge clock) disable iff (reset)
    clock_enable && t2_tick && wrap(second_timer_count, t2_up)
    |=> second_timer_overflow_pulse)
    else $error("Timer 2 wrapped without overflow pulse");

  AST_OV2_QUIET: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !(t2_tick && wrap(second_timer_count, t2_up))
    |=> !second_timer_overflow_pulse)
    else $error("Timer 2 overflow pulse without wrap");

  AST_CASCADE_WRAP: assert property (@(posedge clock) disable iff (reset)
    clock_enable && cascade && state_q.ov1
    && wrap(second_timer_count, first_timer_control[DIR_BIT])
    |=> second_timer_overflow_pulse)
    else $error("Cascaded count did not overflow at its end");

  // Combined count, chaining, freeze and reset

  AST_CHAIN: assert property (@(posedge clock) disable iff (reset)
    !channel_chain_signal)
    else $error("Channel chaining active");

  AST_CONCAT: assert property (@(posedge clock) disable iff (reset)
    cascade_count == {second_timer_count, first_timer_count})
    else $error("Combined count misaligned");

  AST_FREEZE: assert property (@(posedge clock) disable iff (reset)
    !clock_enable
    |=> $stable(cascade_count) && $stable(first_timer_overflow_pulse)
        && $stable(second_timer_overflow_pulse))
    else $error("State moved while clock enable was low");

  AST_RESET_CLEAR: assert property (@(posedge clock)
    reset
    |=> cascade_count == 32'h0000_0000 && !first_timer_overflow_pulse
        && !second_timer_overflow_pulse && !channel_chain_signal)
    else $error("Outputs not cleared by reset");

  // Main scenarios

  COV_CASCADE_STEP: cover property (@(posedge clock) disable iff (reset)
    clock_enable && cascade && state_q.ov1);

  COV_PRESCALED: cover property (@(posedge clock) disable iff (reset)
    clock_enable && !cascade && t2_pre_tick);

  COV_DOWN: cover property (@(posedge clock) disable iff (reset)
    clock_enable && cascade && !t1_up && state_q.ov1);

  COV_FREEZE: cover property (@(posedge clock) disable iff (reset)
    !clock_enable && source_ticks[0]);

  COV_T2_WRAP: cover property (@(posedge clock) disable iff (reset)
    second_timer_overflow_pulse);

endmodule : etc_timer_cascade
`default_nettype wire

// *** etc_pkg.sv ***
// Functional notes
// - Timer 2 clock chosen by control bit 7: timer 1 overflow or prescaled clock.
// - Cascaded, timer 1 overflow reaches timer 2 without prescaler division.
// - Prescaler input is source selected by bits 4:3; its output feeds cascade selector.
// - Cascaded, both timers count in timer 1's direction bit; timer 2's ignored.
// - No channel chaining; only timer 1 and timer 2 form a 32-bit value.
`default_nettype none
package etc_pkg;
  localparam int CTL_W        = 8;
  localparam int CASCADE_BIT  = 7;
  localparam int DIR_BIT      = 6;
  localparam int SRC_LSB      = 3;
  localparam int PRE_LSB      = 0;
  localparam int CHAIN_BIT    = 0;
  localparam logic [15:0] TIMER_RST = 16'h0000;
  localparam logic [2:0]  PRE_RST   = 3'h0;
endpackage : etc_pkg
`default_nettype wire

// *** etc_prescaler.sv ***
`default_nettype none
module etc_prescaler
#(
  parameter int DIV_W = 3
)
(
  // System
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             enable,
  // Control
  input  wire logic [DIV_W-1:0] div_select,
  input  wire logic             tick_in,
  // Output
  output logic                  tick_out
);
  import etc_pkg::*;
  // Counter is seven bits, so divide by 128 at most
  if (DIV_W < 1 || DIV_W > 3)
  begin : g_bad_width
    $error("DIV_W out of range");
  end
  typedef struct packed
  {
    logic [6:0] count;
    logic       tick;
  } etc_pre_state_type;
  etc_pre_state_type state_q;
  etc_pre_state_type state_d;
  logic [6:0] limit;
  always_comb
  begin
    limit = 7'((7'h01 << div_select) - 7'h01);
    state_d = state_q;
    state_d.tick = 1'b0;
    if (tick_in)
    begin
      if (state_q.count >= limit)
      begin
        state_d.count = 7'h00;
        state_d.tick = 1'b1;
      end
      else
        state_d.count = 7'(state_q.count + 7'h01);
    end
  end
  always_ff @(posedge clock)
  begin
    if (reset)
      state_q <= '0;
    else if (enable)
      state_q <= state_d;
  end
  assign tick_out = state_q.tick;
endmodule : etc_prescaler
`default_nettype wire

// *** test_etc_timer_cascade.sv ***
`default_nettype none
module test_etc_timer_cascade;
  timeunit 1ns;
  timeprecision 1ps;
  import etc_pkg::*;
  logic              clock = 1'b0;
  logic              reset = 1'b1;
  logic              clock_enable = 1'b1;
  logic [CTL_W-1:0]  first_timer_control = 8'h40;
  logic [CTL_W-1:0]  second_timer_control = 8'h00;
  logic [3:0]        source_ticks = 4'h0;
  logic [CTL_W-1:0]  channel_control = 8'h00;
  logic [15:0]       first_timer_count;
  logic [15:0]       second_timer_count;
  logic [31:0]       cascade_count;
  logic              channel_chain_signal;
  logic              first_timer_overflow_pulse;
  logic              second_timer_overflow_pulse;
  int                fail_count = 0;
  int                n_tests = 0;
  always #2.5 clock = ~clock;
  etc_timer_cascade etc_timer_cascade_i
  (
    .clock                       (clock),
    .reset                       (reset),
    .clock_enable                (clock_enable),
    .first_timer_control         (first_timer_control),
    .second_timer_control        (second_timer_control),
    .source_ticks                (source_ticks),
    .channel_control             (channel_control),
    .first_timer_count           (first_timer_count),
    .second_timer_count          (second_timer_count),
    .cascade_count               (cascade_count),
    .first_timer_overflow_pulse  (first_timer_overflow_pulse),
    .second_timer_overflow_pulse (second_timer_overflow_pulse),
    .channel_chain_signal        (channel_chain_signal)
  );
  task automatic final_report();
    if (fail_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // Back-to-back ticks, then idle so the lagging timer 2 step settles
  task automatic tick(input logic [3:0] mask, input int n);
    repeat (n)
    begin
      @(negedge clock);
      source_ticks = mask;
    end
    @(negedge clock);
    source_ticks = 4'h0;
    repeat (4) @(negedge clock);
  endtask : tick
  initial
  begin
    #5000;
    fail_count++;
    final_report();
  end
  initial
  begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    cmp(cascade_count, 32'h0000_0000);
    // Source 0, divide by 1, timer 2 counts down
    tick(4'h1, 3);
    cmp({16'h0000, first_timer_count}, 32'h0000_0003);
    cmp({16'h0000, second_timer_count}, 32'h0000_FFFD);
    clock_enable = 1'b0;
    tick(4'h1, 2);
    cmp(cascade_count, 32'hFFFD_0003);
    clock_enable = 1'b1;
    // Source 1, divide by 2, own direction up
    second_timer_control = 8'h49;
    tick(4'h3, 4);
    cmp({16'h0000, first_timer_count}, 32'h0000_0007);
    cmp({16'h0000, second_timer_count}, 32'h0000_FFFF);
    // Cascade, timer 1 down, timer 2 up bit and slowest prescale must be ignored
    first_timer_control = 8'h00;
    second_timer_control = 8'hC7;
    tick(4'h1, 8);
    cmp(cascade_count, 32'hFFFE_FFFF);
    first_timer_control = 8'h40;
    @(negedge clock);
    source_ticks = 4'h1;
    @(negedge clock);
    source_ticks = 4'h0;
    cmp({31'h0000_0000, first_timer_overflow_pulse}, 32'h0000_0001);
    cmp(cascade_count, 32'hFFFE_0000);
    @(negedge clock);
    cmp(cascade_count, 32'hFFFF_0000);
    cmp({31'h0000_0000, first_timer_overflow_pulse}, 32'h0000_0000);
    // Cascade off, divide by 1, up: timer 2 wraps
    second_timer_control = 8'h40;
    source_ticks = 4'h1;
    @(negedge clock);
    source_ticks = 4'h0;
    @(negedge clock);
    cmp({31'h0000_0000, second_timer_overflow_pulse}, 32'h0000_0001);
    cmp({16'h0000, second_timer_count}, 32'h0000_0000);
    @(negedge clock);
    cmp({31'h0000_0000, second_timer_overflow_pulse}, 32'h0000_0000);
    cmp({31'h0000_0000, channel_chain_signal}, 32'h0000_0000);
    final_report();
  end
endmodule : test_etc_timer_cascade
`default_nettype wire
